//--- inc/dac_ctrl_pkg.sv
// Constants, field positions and carrier types of the DAC control bank.
package dac_ctrl_pkg;

  // Register indices on the serial control port.
  localparam logic [6:0] ADDR_MISC       = 7'h02;
  localparam logic [6:0] ADDR_EMPH       = 7'h09;
  localparam logic [6:0] ADDR_IFPWR      = 7'h0A;
  localparam logic [6:0] ADDR_LEGACY     = 7'h0C;
  localparam logic [6:0] ADDR_CH4        = 7'h0F;
  localparam logic [6:0] ADDR_STATUS     = 7'h10;
  localparam logic [6:0] ADDR_SOFT_RESET = 7'h1F;

  // Values after reset.
  localparam logic [8:0] RST_MISC   = 9'h120;
  localparam logic [8:0] RST_EMPH   = 9'h000;
  localparam logic [8:0] RST_IFPWR  = 9'h080;
  localparam logic [8:0] RST_LEGACY = 9'h000;
  localparam logic [8:0] RST_CH4    = 9'h000;

  // Field positions.
  localparam int MISC_EMPH_ALL_BIT  = 1;
  localparam int MISC_SLEEP_BIT     = 2;
  localparam int EMPH_SEL_LSB       = 6;
  localparam int IFPWR_DIS_LSB      = 1;
  localparam int IFPWR_MSLEEP_BIT   = 4;
  localparam int IFPWR_MS_BIT       = 5;
  localparam int IFPWR_RATE_LSB     = 6;
  localparam int LEGACY_ROUTE_LSB   = 0;
  localparam int LEGACY_BYPASS_BIT  = 6;
  localparam int CH4_DIS_BIT        = 1;
  localparam int CH4_ROUTE_HI_BIT   = 3;
  localparam int CH4_EMPH_BIT       = 4;
  localparam int CH4_BYPASS_BIT     = 5;

  // Zero run length that raises a channel's zero flag.
  localparam int         ZCNT_W   = 11;
  localparam logic [10:0] ZERO_RUN = 11'h400;

  // Master clock cycles per frame for each ratio code.
  localparam logic [2:0] RATE_128 = 3'h0;
  localparam logic [2:0] RATE_192 = 3'h1;
  localparam logic [2:0] RATE_256 = 3'h2;
  localparam logic [2:0] RATE_384 = 3'h3;
  localparam logic [2:0] RATE_512 = 3'h4;
  localparam logic [2:0] RATE_768 = 3'h5;
  localparam logic [9:0] CYC_128  = 10'h080;
  localparam logic [9:0] CYC_192  = 10'h0C0;
  localparam logic [9:0] CYC_256  = 10'h100;
  localparam logic [9:0] CYC_384  = 10'h180;
  localparam logic [9:0] CYC_512  = 10'h200;
  localparam logic [9:0] CYC_768  = 10'h300;
  // Log2 of the bit clocks per frame (64); every ratio is a whole multiple of 64.
  localparam int BCLK_SHIFT = 6;

  // One write from the serial control decoder.
  typedef struct packed {
    logic       we;
    logic [6:0] addr;
    logic [8:0] data;
  } wr_req_t;

endpackage : dac_ctrl_pkg

//--- verilog/dac_ctrl.sv
// Control bank of the four-channel DAC: emphasis, power, clocks, mute pin.
`timescale 1ns/10ps
module dac_ctrl
  import dac_ctrl_pkg::*;
#(
  parameter int NCH = 4
) (
  // Clock and reset.
  input  wire logic             ref_clk,
  input  wire logic             rst,
  // Register port from the serial control decoder.
  input  wire wr_req_t          wr_req,
  input  wire logic [6:0]       rd_addr,
  output logic      [8:0]       rd_data,
  // Sample status from the audio input, one bit per channel.
  input  wire logic [NCH-1:0]   sample_valid,
  input  wire logic [NCH-1:0]   sample_zero,
  // Mute pin, and a strap choosing whether the device drives it.
  input  wire logic             mute_pin_in,
  output logic                  mute_pin_out,
  output logic                  mute_pin_oe,
  input  wire logic             mute_pin_drive,
  // Frame and bit clock pins.
  input  wire logic             frame_clk_in,
  input  wire logic             bit_clk_in,
  output logic                  frame_clk_out,
  output logic                  bit_clk_out,
  output logic                  clk_pins_oe,
  output logic                  frame_clk_int,
  output logic                  bit_clk_int,
  // Controls to the converter datapath.
  output logic      [NCH-1:0]   emphasis_en,
  output logic      [NCH-1:0]   channel_on,
  output logic                  midrail_reference,
  output logic                  samples_discard,
  output logic                  filter_reinit,
  output logic      [NCH-1:0]   pin_softmute,
  output logic      [NCH-1:0]   zero_flag
);

  logic [8:0]        misc_ff;
  logic [8:0]        emph_ff;
  logic [8:0]        ifpwr_ff;
  logic [8:0]        legacy_ff;
  logic [8:0]        ch4_ff;
  logic [1:0]        mute_sync_ff;
  logic [1:0]        fclk_sync_ff;
  logic [1:0]        bclk_sync_ff;
  logic              sleep_prev_ff;
  logic [9:0]        fcnt_ff;
  logic [3:0]        bcnt_ff;
  logic [9:0]        ratio_cycles;
  logic [3:0]        bit_div;
  logic [3:0]        emphasis_filter_sel;
  logic [3:0]        channel_disable;
  logic              emphasis_filter_all;
  logic              dac_global_sleep;
  logic              master_sleep;
  logic              clock_master_sel;
  logic [2:0]        zero_flag_route_sel;
  logic              mute_decode_bypass;
  logic [3:0]        route_mask;
  logic [NCH-1:0]    zflag_w;
  logic [3:0]        nxt_pin_softmute;

  // Register fields gathered from the bank.
  assign emphasis_filter_all = misc_ff[MISC_EMPH_ALL_BIT];
  assign dac_global_sleep    = misc_ff[MISC_SLEEP_BIT];
  assign emphasis_filter_sel = {ch4_ff[CH4_EMPH_BIT],
                                emph_ff[EMPH_SEL_LSB +: 3]};
  assign channel_disable     = {ch4_ff[CH4_DIS_BIT],
                                ifpwr_ff[IFPWR_DIS_LSB +: 3]};
  assign master_sleep        = ifpwr_ff[IFPWR_MSLEEP_BIT];
  assign clock_master_sel    = ifpwr_ff[IFPWR_MS_BIT];
  assign zero_flag_route_sel = {ch4_ff[CH4_ROUTE_HI_BIT],
                                legacy_ff[LEGACY_ROUTE_LSB +: 2]};
  assign mute_decode_bypass  = legacy_ff[LEGACY_BYPASS_BIT] |
                               ch4_ff[CH4_BYPASS_BIT];

  // Register bank. Sleep bits never touch it, so settings survive.
  always_ff @(posedge ref_clk) begin
    if (rst || (wr_req.we && wr_req.addr == ADDR_SOFT_RESET)) begin
      misc_ff   <= RST_MISC;
      emph_ff   <= RST_EMPH;
      ifpwr_ff  <= RST_IFPWR;
      legacy_ff <= RST_LEGACY;
      ch4_ff    <= RST_CH4;
    end else if (wr_req.we) begin
      case (wr_req.addr)
        ADDR_MISC:   misc_ff   <= wr_req.data;
        ADDR_EMPH:   emph_ff   <= wr_req.data;
        ADDR_IFPWR:  ifpwr_ff  <= wr_req.data;
        ADDR_LEGACY: legacy_ff <= wr_req.data;
        ADDR_CH4:    ch4_ff    <= wr_req.data;
        default:     misc_ff   <= misc_ff;
      endcase
    end
  end

  // Read-back, one cycle after the address; the status word shows flags.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rd_data <= 9'h000;
    end else begin
      case (rd_addr)
        ADDR_MISC:   rd_data <= misc_ff;
        ADDR_EMPH:   rd_data <= emph_ff;
        ADDR_IFPWR:  rd_data <= ifpwr_ff;
        ADDR_LEGACY: rd_data <= legacy_ff;
        ADDR_CH4:    rd_data <= ch4_ff;
        ADDR_STATUS: rd_data <= {3'h0, mute_pin_out, mute_sync_ff[1],
                                 4'(zflag_w)};
        default:     rd_data <= 9'h000;
      endcase
    end
  end

  // Pin synchronisers; only the second stage is ever looked at.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      mute_sync_ff <= 2'h0;
      fclk_sync_ff <= 2'h0;
      bclk_sync_ff <= 2'h0;
    end else begin
      mute_sync_ff <= {mute_sync_ff[0], mute_pin_in};
      fclk_sync_ff <= {fclk_sync_ff[0], frame_clk_in};
      bclk_sync_ff <= {bclk_sync_ff[0], bit_clk_in};
    end
  end

  // Emphasis and power outputs.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      emphasis_en       <= '0;
      channel_on        <= '0;
      midrail_reference <= 1'b0;
      samples_discard   <= 1'b1;
    end else begin
      emphasis_en <= NCH'(emphasis_filter_sel) |
                     {NCH{emphasis_filter_all}};
      if (dac_global_sleep || master_sleep) begin
        channel_on <= '0;
      end else begin
        channel_on <= ~NCH'(channel_disable);
      end
      midrail_reference <= ~master_sleep;
      samples_discard   <= dac_global_sleep | master_sleep;
    end
  end

  // Filter restart pulse on the falling edge of the global sleep bit.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      sleep_prev_ff <= 1'b0;
      filter_reinit <= 1'b0;
    end else begin
      sleep_prev_ff <= dac_global_sleep;
      filter_reinit <= sleep_prev_ff & ~dac_global_sleep;
    end
  end

  // Ratio decode; reserved codes fall back to the reset ratio.
  always_comb begin
    case (ifpwr_ff[IFPWR_RATE_LSB +: 3])
      RATE_128: ratio_cycles = CYC_128;
      RATE_192: ratio_cycles = CYC_192;
      RATE_256: ratio_cycles = CYC_256;
      RATE_384: ratio_cycles = CYC_384;
      RATE_512: ratio_cycles = CYC_512;
      RATE_768: ratio_cycles = CYC_768;
      default:  ratio_cycles = CYC_256;
    endcase
    bit_div = 4'(ratio_cycles >> BCLK_SHIFT);
  end

  // Frame and bit clock divider, kept aligned at every frame start.
  always_ff @(posedge ref_clk) begin
    if (rst || !clock_master_sel) begin
      fcnt_ff       <= 10'h000;
      bcnt_ff       <= 4'h0;
      frame_clk_out <= 1'b0;
      bit_clk_out   <= 1'b0;
    end else begin
      if (fcnt_ff >= ratio_cycles - 10'h001) begin
        fcnt_ff <= 10'h000;
        bcnt_ff <= 4'h0;
      end else begin
        fcnt_ff <= fcnt_ff + 10'h001;
        bcnt_ff <= (bcnt_ff >= bit_div - 4'h1) ? 4'h0 : bcnt_ff + 4'h1;
      end
      frame_clk_out <= fcnt_ff < (ratio_cycles >> 1);
      bit_clk_out   <= bcnt_ff < (bit_div >> 1);
    end
  end

  // Pin direction follows master select; slave clocks come from pins.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      clk_pins_oe   <= 1'b0;
      frame_clk_int <= 1'b0;
      bit_clk_int   <= 1'b0;
    end else begin
      clk_pins_oe   <= clock_master_sel;
      frame_clk_int <= clock_master_sel ? frame_clk_out
                                        : fclk_sync_ff[1];
      bit_clk_int   <= clock_master_sel ? bit_clk_out
                                        : bclk_sync_ff[1];
    end
  end

  // Zero run counters, one per channel; sleep wipes the history.
  genvar ch;
  generate
    for (ch = 0; ch < NCH; ch++) begin : g_zero
      logic [ZCNT_W-1:0] zcnt_ff;
      always_ff @(posedge ref_clk) begin
        if (rst || samples_discard) begin
          zcnt_ff <= '0;
        end else if (sample_valid[ch]) begin
          if (!sample_zero[ch]) begin
            zcnt_ff <= '0;
          end else if (zcnt_ff != ZERO_RUN) begin
            zcnt_ff <= zcnt_ff + 11'h001;
          end
        end
      end
      assign zflag_w[ch] = (zcnt_ff == ZERO_RUN);
    end
  endgenerate
  assign zero_flag = zflag_w;

  // The same routing table serves the pin as input and as output.
  always_comb begin
    case (zero_flag_route_sel)
      3'h0:    route_mask = 4'hF;
      3'h1:    route_mask = 4'h1;
      3'h2:    route_mask = 4'h2;
      3'h3:    route_mask = 4'h4;
      3'h4:    route_mask = 4'h8;
      3'h5:    route_mask = 4'h3;
      3'h6:    route_mask = 4'h7;
      3'h7:    route_mask = 4'hC;
      default: route_mask = 4'hF;
    endcase
    if (!mute_sync_ff[1]) begin
      nxt_pin_softmute = 4'h0;
    end else if (mute_decode_bypass) begin
      nxt_pin_softmute = 4'hF;
    end else begin
      nxt_pin_softmute = route_mask;
    end
  end

  // Mute pin drive and softmute. The pin level read back includes our
  // own drive, so a reported zero flag also mutes its channels.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      mute_pin_out <= 1'b0;
      mute_pin_oe  <= 1'b0;
      pin_softmute <= '0;
    end else begin
      mute_pin_out <= &(4'(zflag_w) | ~route_mask);
      mute_pin_oe  <= mute_pin_drive;
      pin_softmute <= NCH'(nxt_pin_softmute);
    end
  end

  // Checks.
  AST_EMPH: assert property (@(posedge ref_clk) disable iff (rst)
    ##1 emphasis_en == ($past(NCH'(emphasis_filter_sel)) |
                        {NCH{$past(emphasis_filter_all)}}))
    else $error("Emphasis enable does not match selection.");
  AST_SLEEP: assert property (@(posedge ref_clk) disable iff (rst)
    dac_global_sleep |=> channel_on == '0 && samples_discard)
    else $error("Global sleep left a channel powered.");
  AST_MASTER: assert property (@(posedge ref_clk) disable iff (rst)
    master_sleep |=> !midrail_reference && channel_on == '0)
    else $error("Master sleep left the reference on.");
  AST_DISABLE: assert property (@(posedge ref_clk) disable iff (rst)
    !dac_global_sleep && !master_sleep
      |=> channel_on == ~$past(NCH'(channel_disable)))
    else $error("Channel disable not applied.");
  AST_REINIT: assert property (@(posedge ref_clk) disable iff (rst)
    $fell(dac_global_sleep) |=> filter_reinit ##1 !filter_reinit)
    else $error("Filter restart pulse missing after wake.");
  AST_SLAVE: assert property (@(posedge ref_clk) disable iff (rst)
    !clock_master_sel |=> !clk_pins_oe && !frame_clk_out)
    else $error("Clock pins driven in slave mode.");
  // A write that may change the ratio abandons the frame in flight.
  AST_FRAME: assert property (@(posedge ref_clk)
    disable iff (rst || (wr_req.we && (wr_req.addr == ADDR_IFPWR ||
                                       wr_req.addr == ADDR_SOFT_RESET)))
    $rose(frame_clk_out) && clock_master_sel &&
      ifpwr_ff[IFPWR_RATE_LSB +: 3] == RATE_128
      |-> ##128 $rose(frame_clk_out))
    else $error("Frame period wrong at ratio 128.");
  AST_ZFLAG: assert property (@(posedge ref_clk) disable iff (rst)
    $rose(zflag_w[0]) |-> $past(sample_valid[0] && sample_zero[0]))
    else $error("Zero flag rose without a zero sample.");
  AST_BYPASS: assert property (@(posedge ref_clk) disable iff (rst)
    mute_sync_ff[1] && mute_decode_bypass |=> pin_softmute == '1)
    else $error("Bypassed mute pin did not mute all channels.");
  AST_ROUTE: assert property (@(posedge ref_clk) disable iff (rst)
    zero_flag_route_sel == 3'h1 && zflag_w[0] |=> mute_pin_out)
    else $error("Routed zero flag did not raise the mute pin.");
  AST_DECODE: assert property (@(posedge ref_clk) disable iff (rst)
    mute_sync_ff[1] && !mute_decode_bypass &&
      zero_flag_route_sel == 3'h7 |=> pin_softmute == NCH'(4'hC))
    else $error("Decoded mute hit the wrong channels.");

  COV_MASTER: cover property (@(posedge ref_clk) disable iff (rst)
    clock_master_sel && $rose(frame_clk_out));
  COV_WAKE: cover property (@(posedge ref_clk) disable iff (rst)
    filter_reinit);
  COV_ALLZERO: cover property (@(posedge ref_clk) disable iff (rst)
    &zflag_w && mute_pin_out);
  COV_BYPASS: cover property (@(posedge ref_clk) disable iff (rst)
    mute_decode_bypass && pin_softmute == '1);

endmodule : dac_ctrl

//--- testbench/audio_source_model.sv
// Behavioural audio source: sample strobes and slave-mode pin clocks.
`timescale 1ns/10ps
module audio_source_model (
  // Clock.
  input  wire logic ref_clk,
  // Pin clocks run while this is high.
  input  wire logic clk_run,
  // Sample strobes and pin clocks toward the device.
  output logic [3:0] sample_valid,
  output logic [3:0] sample_zero,
  output logic       frame_clk_in,
  output logic       bit_clk_in
);
  logic [7:0] div_ff;

  // Quiet strobes at time zero.
  initial begin
    sample_valid = 4'h0;
    sample_zero  = 4'hF;
    div_ff       = 8'h00;
  end

  // Pin clocks stand still outside traffic; 64 bit clocks a frame.
  always @(negedge ref_clk) begin
    if (clk_run) begin
      div_ff <= div_ff + 8'h01;
    end
  end
  assign frame_clk_in = div_ff[7];
  assign bit_clk_in   = div_ff[1];

  // One sample a channel every other cycle; zero where zmask is set.
  // Between strobes the zero line shows the inverse so it carries no meaning.
  task automatic send(input int n, input logic [3:0] zmask);
    repeat (n) begin
      @(negedge ref_clk);
      sample_valid = 4'hF;
      sample_zero  = zmask;
      @(negedge ref_clk);
      sample_valid = 4'h0;
      sample_zero  = ~zmask;
    end
  endtask : send
endmodule : audio_source_model

//--- testbench/dac_emphasis_power_clock_control_bench.sv
// Self-checking bench of the DAC control bank with random stimulus.
`timescale 1ns/10ps
module dac_emphasis_power_clock_control_bench;
  import dac_ctrl_pkg::*;
  logic       ref_clk, rst, ext_mute, mute_drive, clk_run, mute_wire;
  wr_req_t    wreq;
  logic [6:0] rd_addr;
  logic [8:0] rd_data;
  logic [3:0] s_valid, s_zero, emph, ch_on, softmute, zflag;
  logic       m_out, m_oe, f_in, b_in, f_out, b_out, c_oe;
  logic       midrail, discard, reinit;
  logic       f_int, b_int;
  logic [1:0] hf, hb;
  int         fails, total_checks, per, hi, bits, b, r;
  logic [3:0] s, d, m;
  logic       a, gs, ms;

  dac_ctrl dut (.ref_clk(ref_clk), .rst(rst), .wr_req(wreq),
    .rd_addr(rd_addr), .rd_data(rd_data), .sample_valid(s_valid),
    .sample_zero(s_zero), .mute_pin_in(mute_wire), .mute_pin_out(m_out),
    .mute_pin_oe(m_oe), .mute_pin_drive(mute_drive),
    .frame_clk_in(f_in), .bit_clk_in(b_in), .frame_clk_out(f_out),
    .bit_clk_out(b_out), .clk_pins_oe(c_oe), .frame_clk_int(f_int),
    .bit_clk_int(b_int), .emphasis_en(emph), .channel_on(ch_on),
    .midrail_reference(midrail), .samples_discard(discard),
    .filter_reinit(reinit), .pin_softmute(softmute), .zero_flag(zflag));
  audio_source_model src (.ref_clk(ref_clk), .clk_run(clk_run),
    .sample_valid(s_valid), .sample_zero(s_zero),
    .frame_clk_in(f_in), .bit_clk_in(b_in));

  // The mute pin resolves from the device drive and the outside level.
  assign mute_wire = m_oe ? m_out : ext_mute;

  // 10 MHz master clock.
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  // Mask of channels picked by a routing code.
  function automatic logic [3:0] rmask(input logic [2:0] c);
    logic [3:0] t[8] = '{4'hF, 4'h1, 4'h2, 4'h4, 4'h8, 4'h3, 4'h7, 4'hC};
    return t[c];
  endfunction : rmask

  // Frame length of a ratio code; reserved codes act as 256.
  function automatic logic [31:0] cyc(input logic [2:0] c);
    logic [9:0] t[8] = '{CYC_128, CYC_192, CYC_256, CYC_384, CYC_512,
                         CYC_768, CYC_256, CYC_256};
    return {22'h0, t[c]};
  endfunction : cyc

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // Write is taken at one edge; derived outputs settle one edge later.
  task automatic wr(input logic [6:0] ad, input logic [8:0] dt);
    @(negedge ref_clk);
    wreq = '{we: 1'b1, addr: ad, data: dt};
    @(negedge ref_clk);
    wreq.we = 1'b0;
    @(negedge ref_clk);
  endtask : wr

  task automatic rd(input logic [6:0] ad, output logic [8:0] dt);
    @(negedge ref_clk);
    rd_addr = ad;
    @(negedge ref_clk);
    dt = rd_data;
  endtask : rd

  // Period, high time and bit clocks of one frame in master mode.
  task automatic measure();
    logic pf, pb;
    int   n;
    n = 0;
    while (f_out !== 1'b0 && n < 2000) begin
      @(negedge ref_clk);
      n++;
    end
    while (f_out !== 1'b1 && n < 4000) begin
      @(negedge ref_clk);
      n++;
    end
    per = 0;
    hi = 0;
    bits = 0;
    pf = 1'b1;
    pb = b_out;
    do begin
      @(negedge ref_clk);
      per++;
      hi += int'(f_out);
      bits += int'(pb && !b_out);
      n = int'(!pf && f_out);
      pf = f_out;
      pb = b_out;
    end while (n == 0 && per < 2000);
  endtask : measure

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : report_and_stop

  // Watchdog sized well above the expected run length.
  initial begin
    repeat (60000) @(posedge ref_clk);
    fails++;
    report_and_stop();
  end

  initial begin
    logic [8:0] v;
    logic [6:0] ra[6] = '{ADDR_MISC, ADDR_EMPH, ADDR_IFPWR, ADDR_LEGACY,
                          ADDR_CH4, 7'h03};
    logic [8:0] rv[6] = '{RST_MISC, RST_EMPH, RST_IFPWR, RST_LEGACY,
                          RST_CH4, 9'h000};
    rst = 1'b1;
    wreq = '0;
    rd_addr = 7'h00;
    ext_mute = 1'b0;
    mute_drive = 1'b0;
    clk_run = 1'b0;
    fails = 0;
    total_checks = 0;
    r = $urandom(1);
    repeat (12) @(posedge ref_clk);
    @(negedge ref_clk);
    rst = 1'b0;
    // Defaults after reset, including an unmapped index.
    for (int i = 0; i < 6; i++) begin
      rd(ra[i], v);
      chk(v, rv[i]);
    end
    chk(c_oe, 1'b0);
    chk({midrail, discard, ch_on}, 6'h2F);
    $display("reset test done");
    // Emphasis from the select bits and the global bit.
    for (int i = 0; i < 10; i++) begin
      s = (i == 0) ? 4'hF : 4'($urandom);
      a = (i == 1) ? 1'b1 : 1'($urandom);
      wr(ADDR_EMPH, {s[2:0], 6'h00});
      wr(ADDR_CH4, {4'h0, s[3], 4'h0});
      wr(ADDR_MISC, RST_MISC | {7'h00, a, 1'b0});
      chk(emph, s | {4{a}});
    end
    $display("emphasis test done");
    // Channel disables under both sleeps; channels go down before sleep.
    for (int i = 0; i < 12; i++) begin
      d = 4'($urandom);
      gs = (i < 2) ? 1'b0 : 1'($urandom);
      ms = (i < 2) ? 1'b0 : 1'($urandom);
      wr(ADDR_CH4, {7'h00, d[3], 1'b0});
      wr(ADDR_IFPWR, RST_IFPWR | {5'h00, d[2:0], 1'b0});
      wr(ADDR_IFPWR, RST_IFPWR | {4'h0, ms, d[2:0], 1'b0});
      wr(ADDR_MISC, RST_MISC | {6'h00, gs, 2'h0});
      chk(ch_on, (gs | ms) ? 4'h0 : 4'(~d));
      chk({midrail, discard}, {~ms, gs | ms});
      rd(ADDR_IFPWR, v);
      chk(v, RST_IFPWR | {4'h0, ms, d[2:0], 1'b0});
    end
    wr(ADDR_IFPWR, RST_IFPWR);
    wr(ADDR_MISC, RST_MISC | 9'h004);
    wr(ADDR_MISC, RST_MISC);
    chk(reinit, 1'b1);
    @(negedge ref_clk);
    chk(reinit, 1'b0);
    $display("power test done");
    // Zero flags on channels 1 and 2 after exactly 1024 zero samples.
    src.send(1023, 4'h3);
    chk(zflag, 4'h0);
    src.send(1, 4'h3);
    chk(zflag, 4'h3);
    // Status word: pin drive and pin level low, flags of channels 1 and 2.
    rd(ADDR_STATUS, v);
    chk(v, 9'h003);
    // Every routing code, driven by the device and then from outside.
    for (int dr = 1; dr >= 0; dr--) begin
      mute_drive = dr[0];
      ext_mute = 1'b1;
      for (int c = 0; c < 8; c++) begin
        b = $urandom % 3;
        m = rmask(3'(c));
        wr(ADDR_LEGACY, {2'h0, b == 1, 4'h0, 2'(c)});
        wr(ADDR_CH4, {3'h0, b == 2, 1'b0, c[2], 3'h0});
        repeat (6) @(negedge ref_clk);
        chk(m_oe, dr[0]);
        if (dr == 1) begin
          a = &(4'h3 | ~m);
          chk(m_out, a);
          chk(softmute, a ? ((b != 0) ? 4'hF : m) : 4'h0);
        end else begin
          chk(softmute, (b != 0) ? 4'hF : m);
        end
      end
    end
    ext_mute = 1'b0;
    repeat (6) @(negedge ref_clk);
    chk(softmute, 4'h0);
    wr(ADDR_MISC, RST_MISC | 9'h004);
    // The counters clear one edge after the registered discard rises.
    @(negedge ref_clk);
    chk(zflag, 4'h0);
    wr(ADDR_MISC, RST_MISC);
    $display("mute test done");
    // Slave mode leaves the clock pins to the source; the internal clocks
    // follow the pins three edges late, through the synchronisers and the output register.
    clk_run = 1'b1;
    for (int i = 0; i < 300; i++) begin
      @(negedge ref_clk);
      if (i > 3) begin
        chk({f_int, b_int}, {hf[1], hb[1]});
      end
      hf = {hf[0], f_in};
      hb = {hb[0], b_in};
    end
    chk({c_oe, f_out, b_out}, 3'h0);
    clk_run = 1'b0;
    // Master mode frame for every ratio code.
    for (int c = 0; c < 8; c++) begin
      wr(ADDR_IFPWR, {3'(c), 6'h20});
      measure();
      chk(c_oe, 1'b1);
      chk(per, cyc(3'(c)));
      chk(hi, cyc(3'(c)) >> 1);
      chk(bits, 32'h1 << BCLK_SHIFT);
      // In master mode the internal clocks are the own clocks, one edge late.
      {a, gs} = {f_out, b_out};
      @(negedge ref_clk);
      chk({f_int, b_int}, {a, gs});
    end
    // The soft reset index restores the defaults, slave mode included.
    wr(ADDR_SOFT_RESET, 9'h1FF);
    rd(ADDR_IFPWR, v);
    chk(v, RST_IFPWR);
    chk(c_oe, 1'b0);
    $display("clock test done");
    report_and_stop();
  end
endmodule : dac_emphasis_power_clock_control_bench
